// ### hdl/port_pin_top.sv
// Pin control for three 8-bit ports with bus, A-D and interrupt functions.
// Assumes a classic Wishbone master and pins resolved by the surroundings.
//
// How it works
// (R1) Strap low starts single-chip mode, strap high starts microprocessor.
// (R2) Reset puts every register and pin control into its reset state.
// (R3) Bus-width strap low gives a 16-bit bus, high an 8-bit one.
// (R4) The board holds the bus-width strap constant while running.
// (R5) The board ties the bus-width strap low when no bus is used.
// (R6) Every port-zero pin has its own direction bit.
// (R7) Single-chip pull-ups are switched in groups of four pins.
// (R8) Pull-ups are unavailable in expansion and microprocessor modes.
// (R9) In single-chip mode port zero may feed the A-D converter.
// (R10) Ports one and two behave like port zero.
// (R11) A separate bus uses port zero as the low data byte.
// (R12) A separate bus uses port one as the high data byte.
// (R13) Top three port-one pins can raise external interrupt requests.
// (R14) The mode strap is caught after reset and kept until next reset.
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module port_pin_top (
    input  wire logic                              REF_CLK,
    input  wire logic                              RST,
    input  wire logic                              WB_CYC_I,
    input  wire logic                              WB_STB_I,
    input  wire logic                              WB_WE_I,
    input  wire logic [port_pin_pkg::WB_ADR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]                        WB_SEL_I,
    input  wire logic [port_pin_pkg::WB_DAT_W-1:0] WB_DAT_I,
    output logic      [port_pin_pkg::WB_DAT_W-1:0] WB_DAT_O,
    output logic                                   WB_ACK_O,
    input  wire logic                              PROCESSOR_MODE_STRAP,
    input  wire logic                              BUS_WIDTH_STRAP,
    input  wire logic [port_pin_pkg::PIN_W-1:0]    PIN_IN,
    output logic      [port_pin_pkg::PIN_W-1:0]    PIN_OUT,
    output logic      [port_pin_pkg::PIN_W-1:0]    PIN_OE,
    output logic      [port_pin_pkg::PIN_W-1:0]    PULLUP_EN,
    input  wire logic [port_pin_pkg::BUS_W-1:0]    BUS_WDATA,
    input  wire logic                              BUS_DRIVE,
    output logic      [port_pin_pkg::BUS_W-1:0]    BUS_RDATA,
    output logic                                   BUS_ACTIVE,
    output logic                                   BUS_WIDE,
    output logic                                   ADC_EXT_EN,
    output logic      [port_pin_pkg::IRQ_PINS-1:0] IRQ_REQ
);

    port_pin_pkg::port_cfg_s              cfg_q [port_pin_pkg::PORTS];
    logic [port_pin_pkg::PULL_W-1:0]      pull_q;
    logic [port_pin_pkg::FUNC_W-1:0]      func_q;
    port_pin_pkg::mode_e                  mode_q;
    logic                                 cap_q;
    logic                                 strap_q;
    logic                                 bus16_q;
    logic [port_pin_pkg::IRQ_PINS-1:0]    irq_prev_q;
    logic                                 ack_q;
    logic [port_pin_pkg::WB_DAT_W-1:0]    rd_d;
    logic                                 wr_hit;
    logic                                 single;
    logic                                 bus_act;
    logic                                 adc_act;
    logic [port_pin_pkg::IRQ_PINS-1:0]    irq_pins;
    logic [port_pin_pkg::IRQ_PINS-1:0]    irq_en;
    logic [port_pin_pkg::PIN_W-1:0]       out_d;
    logic [port_pin_pkg::PIN_W-1:0]       oe_d;
    logic [port_pin_pkg::PIN_W-1:0]       pu_d;
    logic [port_pin_pkg::PIN_W-1:0]       bus_w24;
    logic [port_pin_pkg::PORTS-1:0]       alt_vec;
    logic [port_pin_pkg::PORTS-1:0]       force_vec;

    assign single   = (mode_q == port_pin_pkg::MODE_SINGLE);
    assign bus_act  = ~single & func_q[port_pin_pkg::FUNC_SEP_BUS];
    assign adc_act  = single & func_q[port_pin_pkg::FUNC_ADC];
    assign irq_pins = PIN_IN[port_pin_pkg::IRQ_BASE +: port_pin_pkg::IRQ_PINS];
    assign irq_en   = func_q[port_pin_pkg::FUNC_IRQ_LSB +:
                             port_pin_pkg::IRQ_PINS];
    assign bus_w24  = {8'h00, BUS_WDATA};
    // (R11) low byte on port zero
    // (R12) high byte on port one
    assign alt_vec  = {1'b0, bus_act & bus16_q, bus_act};
    assign force_vec = {2'b00, adc_act};
    // Writes commit at the edge where the master samples ack.
    assign wr_hit   = WB_CYC_I & WB_STB_I & ack_q & WB_WE_I & WB_SEL_I[0];

    // (R14) strap caught after release
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            cap_q   <= 1'b0;
            strap_q <= 1'b0;
        end
        else if (!cap_q)
        begin
            cap_q   <= 1'b1;
            strap_q <= PROCESSOR_MODE_STRAP;
        end
    end

    // (R1) mode from strap
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            mode_q <= port_pin_pkg::MODE_SINGLE;
        end
        else if (!cap_q)
        begin
            mode_q <= PROCESSOR_MODE_STRAP ? port_pin_pkg::MODE_MICRO
                                           : port_pin_pkg::MODE_SINGLE;
        end
        else if (!strap_q)
        begin
            mode_q <= func_q[port_pin_pkg::FUNC_EXPAND]
                      ? port_pin_pkg::MODE_EXPANSION
                      : port_pin_pkg::MODE_SINGLE;
        end
    end

    // (R3) bus width from strap
    // (R4) strap assumed constant, so no filtering
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            bus16_q <= 1'b1;
        end
        else
        begin
            bus16_q <= ~BUS_WIDTH_STRAP;
        end
    end

    // (R2) register reset
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            for (int g = 0; g < port_pin_pkg::PORTS; g++)
            begin
                cfg_q[g].latch <= port_pin_pkg::RST_LATCH;
                cfg_q[g].dir   <= port_pin_pkg::RST_DIR;
            end
            pull_q <= port_pin_pkg::RST_PULL;
            func_q <= port_pin_pkg::RST_FUNC;
        end
        else if (wr_hit)
        begin
            for (int g = 0; g < port_pin_pkg::PORTS; g++)
            begin
                if (WB_ADR_I == port_pin_pkg::adr_t'(port_pin_pkg::OFF_DATA0
                    + g * port_pin_pkg::PORT_STRIDE))
                begin
                    cfg_q[g].latch <= WB_DAT_I[port_pin_pkg::PORT_W-1:0];
                end
                else if (WB_ADR_I == port_pin_pkg::adr_t'(
                         port_pin_pkg::OFF_DIR0
                         + g * port_pin_pkg::PORT_STRIDE))
                begin
                    cfg_q[g].dir <= WB_DAT_I[port_pin_pkg::PORT_W-1:0];
                end
            end
            if (WB_ADR_I == port_pin_pkg::OFF_PULL)
            begin
                pull_q <= WB_DAT_I[port_pin_pkg::PULL_W-1:0];
            end
            else if (WB_ADR_I == port_pin_pkg::OFF_FUNC)
            begin
                func_q <= WB_DAT_I[port_pin_pkg::FUNC_W-1:0];
            end
        end
    end

    // Data registers read the latch on outputs and the pin on inputs.
    always_comb
    begin
        rd_d = '0;
        for (int g = 0; g < port_pin_pkg::PORTS; g++)
        begin
            if (WB_ADR_I == port_pin_pkg::adr_t'(port_pin_pkg::OFF_DATA0
                + g * port_pin_pkg::PORT_STRIDE))
            begin
                rd_d[port_pin_pkg::PORT_W-1:0] =
                    (cfg_q[g].dir & cfg_q[g].latch)
                    | (~cfg_q[g].dir
                       & PIN_IN[g * port_pin_pkg::PORT_W +:
                                port_pin_pkg::PORT_W]);
            end
            else if (WB_ADR_I == port_pin_pkg::adr_t'(
                     port_pin_pkg::OFF_DIR0
                     + g * port_pin_pkg::PORT_STRIDE))
            begin
                rd_d[port_pin_pkg::PORT_W-1:0] = cfg_q[g].dir;
            end
        end
        if (WB_ADR_I == port_pin_pkg::OFF_PULL)
        begin
            rd_d[port_pin_pkg::PULL_W-1:0] = pull_q;
        end
        else if (WB_ADR_I == port_pin_pkg::OFF_FUNC)
        begin
            rd_d[port_pin_pkg::FUNC_W-1:0] = func_q;
        end
        else if (WB_ADR_I == port_pin_pkg::OFF_STATUS)
        begin
            rd_d[port_pin_pkg::ST_SINGLE] = single;
            rd_d[port_pin_pkg::ST_EXPAND] =
                (mode_q == port_pin_pkg::MODE_EXPANSION);
            rd_d[port_pin_pkg::ST_MICRO] =
                (mode_q == port_pin_pkg::MODE_MICRO);
            rd_d[port_pin_pkg::ST_BUS16] = bus16_q;
            rd_d[port_pin_pkg::ST_STRAP] = strap_q;
            rd_d[port_pin_pkg::ST_IRQ_LSB +: port_pin_pkg::IRQ_PINS] =
                irq_pins;
        end
        else if (WB_ADR_I == port_pin_pkg::OFF_BUSIN)
        begin
            rd_d[port_pin_pkg::BUS_W-1:0] = BUS_RDATA;
        end
    end

    // Unmapped addresses are acknowledged and read as zero.
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            ack_q    <= 1'b0;
            WB_DAT_O <= '0;
        end
        else
        begin
            ack_q    <= WB_CYC_I & WB_STB_I & ~ack_q;
            WB_DAT_O <= rd_d;
        end
    end
    assign WB_ACK_O = ack_q;

    // (R10) same lane for every port
    for (genvar g = 0; g < port_pin_pkg::PORTS; g++)
    begin : g_port
        port_lane #(
            .WIDTH (port_pin_pkg::PORT_W),
            .GROUP (port_pin_pkg::PULL_GROUP)
        ) u_lane (
            .latch       (cfg_q[g].latch),
            .dir         (cfg_q[g].dir),
            .pull_grp    (pull_q[g * 2 +: 2]),
            .single_chip (single),
            .force_in    (force_vec[g]),
            .alt_act     (alt_vec[g]),
            .alt_drive   (BUS_DRIVE),
            .alt_data    (bus_w24[g * port_pin_pkg::PORT_W +:
                                  port_pin_pkg::PORT_W]),
            .pin_out     (out_d[g * port_pin_pkg::PORT_W +:
                                port_pin_pkg::PORT_W]),
            .pin_oe      (oe_d[g * port_pin_pkg::PORT_W +:
                               port_pin_pkg::PORT_W]),
            .pull_en     (pu_d[g * port_pin_pkg::PORT_W +:
                               port_pin_pkg::PORT_W])
        );
    end

    // (R9) port zero to A-D inputs
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            PIN_OUT    <= '0;
            PIN_OE     <= '0;
            PULLUP_EN  <= '0;
            ADC_EXT_EN <= 1'b0;
            BUS_ACTIVE <= 1'b0;
            BUS_WIDE   <= 1'b0;
        end
        else
        begin
            PIN_OUT    <= out_d;
            PIN_OE     <= oe_d;
            PULLUP_EN  <= pu_d;
            ADC_EXT_EN <= adc_act;
            BUS_ACTIVE <= bus_act;
            BUS_WIDE   <= bus_act & bus16_q;
        end
    end

    // Narrow bus leaves port one to software, so its byte reads zero.
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            BUS_RDATA <= '0;
        end
        else if (bus_act)
        begin
            BUS_RDATA <= {bus16_q ? PIN_IN[15:8] : 8'h00, PIN_IN[7:0]};
        end
    end

    // (R13) falling edge raises request
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            irq_prev_q <= '1;
            IRQ_REQ    <= '0;
        end
        else
        begin
            irq_prev_q <= irq_pins;
            IRQ_REQ    <= irq_en & irq_prev_q & ~irq_pins;
        end
    end

    AST_ACK_ONE: assert property (@(posedge REF_CLK) disable iff (RST) // (R2)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");

    AST_ACK_NEXT: assert property (@(posedge REF_CLK) disable iff (RST) // (R2)
        (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
        else $error("request not acknowledged in one cycle");

    AST_RESET_PINS: assert property (@(posedge REF_CLK) // (R2)
        RST |=> (PIN_OE == '0 && PULLUP_EN == '0 && !WB_ACK_O))
        else $error("pins not released by reset");

    AST_STRAP_MICRO: assert property (@(posedge REF_CLK) // (R1)
        (cap_q && strap_q) |-> mode_q == port_pin_pkg::MODE_MICRO)
        else $error("high strap did not give microprocessor mode");

    AST_STRAP_KEPT: assert property (@(posedge REF_CLK) // (R14)
        disable iff (RST) cap_q |=> (cap_q && $stable(strap_q)))
        else $error("captured strap changed before reset");

    AST_PULL_BUSMODE: assert property (@(posedge REF_CLK) // (R8)
        disable iff (RST) !single |=> PULLUP_EN == '0)
        else $error("pull-up on outside single-chip mode");

    AST_PULL_GROUP: assert property (@(posedge REF_CLK) // (R7)
        disable iff (RST) (single && !pull_q[0]) |=> PULLUP_EN[3:0] == 4'h0)
        else $error("pull-up on in a disabled group");

    AST_ADC_INPUT: assert property (@(posedge REF_CLK) // (R9)
        ADC_EXT_EN |-> (PIN_OE[7:0] == 8'h00 && $past(single)))
        else $error("port zero driven while routed to A-D");

    AST_DIR_OUT: assert property (@(posedge REF_CLK) disable iff (RST) // (R6)
        (!bus_act && !adc_act && cfg_q[0].dir[3]) |=> PIN_OE[3])
        else $error("output pin not driven");

    AST_BUS_LOW: assert property (@(posedge REF_CLK) disable iff (RST) // (R11)
        (bus_act && BUS_DRIVE) |=>
        (PIN_OE[7:0] == 8'hff && PIN_OUT[7:0] == $past(BUS_WDATA[7:0])))
        else $error("low data byte not on port zero");

    AST_BUS_HIGH: assert property (@(posedge REF_CLK) // (R12)
        disable iff (RST) (bus_act && bus16_q && BUS_DRIVE) |=>
        (PIN_OE[15:8] == 8'hff && PIN_OUT[15:8] == $past(BUS_WDATA[15:8])))
        else $error("high data byte not on port one");

    AST_BUS_NARROW: assert property (@(posedge REF_CLK) // (R3)
        disable iff (RST) (bus_act && !bus16_q && cfg_q[1].dir == 8'h00) |=>
        PIN_OE[15:8] == 8'h00)
        else $error("narrow bus drove port one");

    AST_IRQ_CAUSE: assert property (@(posedge REF_CLK) // (R13)
        disable iff (RST) IRQ_REQ[0] |-> ($past(irq_en[0])
        && !$past(irq_pins[0]) && $past(irq_prev_q[0])))
        else $error("interrupt request without enabled falling edge");

endmodule : port_pin_top

// ### hdl/port_pin_pkg.sv
// Constants, types and register map of the three-port pin select block.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package port_pin_pkg;

    localparam int PORTS      = 3;
    localparam int PORT_W     = 8;
    localparam int PIN_W      = PORTS * PORT_W;
    localparam int PULL_GROUP = 4;
    localparam int PULL_W     = PORTS * (PORT_W / PULL_GROUP);
    localparam int IRQ_PINS   = 3;
    localparam int IRQ_BASE   = PORT_W + 5;
    localparam int BUS_W      = 16;
    localparam int WB_ADR_W   = 8;
    localparam int WB_DAT_W   = 32;

    typedef logic [WB_ADR_W-1:0] adr_t;

    // Register byte offsets.
    localparam adr_t OFF_DATA0   = 8'h00;
    localparam adr_t OFF_DIR0    = 8'h04;
    localparam adr_t PORT_STRIDE = 8'h08;
    localparam adr_t OFF_PULL    = 8'h18;
    localparam adr_t OFF_FUNC    = 8'h1c;
    localparam adr_t OFF_STATUS  = 8'h20;
    localparam adr_t OFF_BUSIN   = 8'h24;

    // Function control fields.
    localparam int FUNC_ADC     = 0;
    localparam int FUNC_IRQ_LSB = 1;
    localparam int FUNC_SEP_BUS = 4;
    localparam int FUNC_EXPAND  = 5;
    localparam int FUNC_W       = 6;

    // Status fields.
    localparam int ST_SINGLE    = 0;
    localparam int ST_EXPAND    = 1;
    localparam int ST_MICRO     = 2;
    localparam int ST_BUS16     = 3;
    localparam int ST_STRAP     = 4;
    localparam int ST_IRQ_LSB   = 5;

    // Reset values.
    localparam logic [PORT_W-1:0] RST_LATCH = 8'h00;
    localparam logic [PORT_W-1:0] RST_DIR   = 8'h00;
    localparam logic [PULL_W-1:0] RST_PULL  = 6'h00;
    localparam logic [FUNC_W-1:0] RST_FUNC  = 6'h00;

    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_EXPANSION,
        MODE_MICRO
    } mode_e;

    typedef struct packed {
        logic [PORT_W-1:0] latch;
        logic [PORT_W-1:0] dir;
    } port_cfg_s;

endpackage : port_pin_pkg

// ### hdl/port_lane.sv
// One 8-bit port: per-pin drive, enable and grouped pull-up selection.
// Purely combinational; the caller registers every result.
`timescale 1ns/1ps
module port_lane #(
    parameter int WIDTH = 8,
    parameter int GROUP = 4
) (
    input  wire logic [WIDTH-1:0]       latch,
    input  wire logic [WIDTH-1:0]       dir,
    input  wire logic [WIDTH/GROUP-1:0] pull_grp,
    input  wire logic                   single_chip,
    input  wire logic                   force_in,
    input  wire logic                   alt_act,
    input  wire logic                   alt_drive,
    input  wire logic [WIDTH-1:0]       alt_data,
    output logic      [WIDTH-1:0]       pin_out,
    output logic      [WIDTH-1:0]       pin_oe,
    output logic      [WIDTH-1:0]       pull_en
);

    for (genvar i = 0; i < WIDTH; i++)
    begin : g_pin
        // (R6) per-pin direction
        assign pin_out[i] = alt_act ? alt_data[i] : latch[i];
        assign pin_oe[i]  = alt_act ? alt_drive : (dir[i] & ~force_in);
        // (R7) four-pin pull groups
        // (R8) no pull outside single-chip
        assign pull_en[i] = single_chip & pull_grp[i / GROUP] & ~pin_oe[i]
                            & ~force_in;
    end

endmodule : port_lane

// ### testbench/bus_peripheral.sv
// Behavioural memory or peripheral on the pins of the three ports.
// Assumes the bench gives idle pin levels and the word returned on reads.
`timescale 1ns/1ps
module bus_peripheral (
    input  wire logic [port_pin_pkg::PIN_W-1:0] pin_out,
    input  wire logic [port_pin_pkg::PIN_W-1:0] pin_oe,
    input  wire logic [port_pin_pkg::PIN_W-1:0] pullup_en,
    input  wire logic                           bus_active,
    input  wire logic                           bus_wide,
    input  wire logic [port_pin_pkg::PIN_W-1:0] ext_level,
    input  wire logic [port_pin_pkg::BUS_W-1:0] read_word,
    output logic      [port_pin_pkg::PIN_W-1:0] pin_level
);
    // A pin the device drives wins; otherwise the far side answers.
    always_comb
    begin
        for (int i = 0; i < port_pin_pkg::PIN_W; i++)
        begin
            if (pin_oe[i])
                pin_level[i] = pin_out[i];
            // Data bytes answer; a narrow bus leaves port one.
            else if (bus_active && (i < port_pin_pkg::PORT_W
                     || (bus_wide && i < port_pin_pkg::BUS_W)))
                pin_level[i] = read_word[i];
            else if (pullup_en[i])
                pin_level[i] = 1'b1;
            else
                pin_level[i] = ext_level[i];
        end
    end
endmodule : bus_peripheral

// ### testbench/testbench.sv
// Self-checking bench for the three-port pin select block.
// Assumes the block answers a classic Wishbone master and sees the model.
`timescale 1ns/1ps
module testbench;
    localparam int TIMEOUT = 5000;
    logic        clk, rst, cyc, stb, we, ack, mode_strap, width_strap;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [23:0] pin_in, pin_out, pin_oe, pull_en, ext_level;
    logic [15:0] bus_wdata, bus_rdata, read_word;
    logic        bus_drive, bus_active, bus_wide, adc_en;
    logic [2:0]  irq_req;
    int          failures, n_compared, cycles;

    port_pin_top dut (.REF_CLK(clk), .RST(rst), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .PROCESSOR_MODE_STRAP(mode_strap), .BUS_WIDTH_STRAP(width_strap),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .PULLUP_EN(pull_en), .BUS_WDATA(bus_wdata), .BUS_DRIVE(bus_drive),
        .BUS_RDATA(bus_rdata), .BUS_ACTIVE(bus_active), .BUS_WIDE(bus_wide),
        .ADC_EXT_EN(adc_en), .IRQ_REQ(irq_req));

    bus_peripheral far_side (.pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pull_en), .bus_active(bus_active), .bus_wide(bus_wide),
        .ext_level(ext_level), .read_word(read_word), .pin_level(pin_in));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic final_report;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == TIMEOUT)
        begin
            failures++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask : check

    // Called just after a rising edge; waits on ack with no fixed latency.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'hf;
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, q);
    endtask : rd

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc

    function automatic logic [7:0] data_adr(input int i);
        return port_pin_pkg::OFF_DATA0 + 8'(i) * port_pin_pkg::PORT_STRIDE;
    endfunction : data_adr

    // Straps are set here while reset is held.
    task automatic do_reset(input logic strap, input logic width);
        rst         <= 1'b1;
        mode_strap  <= strap;
        width_strap <= width;
        wait_cyc(10);
        rst <= 1'b0;
        wait_cyc(3);
    endtask : do_reset

    task automatic reset_test;
        logic [31:0] q;
        check({8'h0, pin_oe | pull_en}, 32'h0, "pins after reset");
        check({adc_en, bus_active, irq_req}, 32'h0, "flags reset");
        rd(port_pin_pkg::OFF_STATUS, q);
        check(q & 32'h17, 32'h01, "single-chip status");
    endtask : reset_test

    task automatic dir_test;
        logic [23:0] dirs;
        logic [31:0] q;
        dirs = 24'hc35aa5;
        for (int i = 0; i < 3; i++)
        begin
            wr(data_adr(i), 32'hff);
            wr(data_adr(i) + 8'h04, {24'h0, dirs[i*8 +: 8]});
        end
        wait_cyc(2);
        check({8'h0, pin_oe}, {8'h0, dirs}, "direction");
        check({8'h0, pin_out & pin_oe}, {8'h0, dirs}, "drive");
        rd(data_adr(0), q);
        check(q, 32'ha5, "data readback mix");
    endtask : dir_test

    task automatic pull_adc_test;
        for (int i = 0; i < 3; i++)
            wr(data_adr(i) + 8'h04, 32'h0);
        wr(port_pin_pkg::OFF_DIR0, 32'h01);
        wr(port_pin_pkg::OFF_PULL, 32'h25);
        wait_cyc(2);
        check({8'h0, pull_en}, 32'hf00f0e, "pull groups");
        wr(port_pin_pkg::OFF_DIR0, 32'hff);
        wr(port_pin_pkg::OFF_FUNC, 32'h01);
        wait_cyc(2);
        check({adc_en, pin_oe[7:0], pull_en[7:0]}, 32'h10000, "a-d");
        wr(port_pin_pkg::OFF_FUNC, 32'h0);
        wr(port_pin_pkg::OFF_DIR0, 32'h0);
        wr(port_pin_pkg::OFF_PULL, 32'h0);
    endtask : pull_adc_test

    // enabled pin gives one pulse, masked pin none.
    task automatic irq_test;
        int n0, n1;
        n0 = 0;
        n1 = 0;
        wr(port_pin_pkg::OFF_FUNC, 32'h02);
        ext_level[14:13] <= 2'b11;
        wait_cyc(3);
        ext_level[14:13] <= 2'b00;
        repeat (8)
        begin
            @(posedge clk);
            n0 += (irq_req[0] === 1'b1);
            n1 += (irq_req[1] === 1'b1);
        end
        check(n0, 1, "enabled irq pulses");
        check(n1, 0, "masked irq pulses");
        wr(port_pin_pkg::OFF_FUNC, 32'h0);
    endtask : irq_test

    // separate 16-bit bus in expansion mode.
    task automatic expand_test;
        logic [31:0] q;
        wr(8'h30, 32'hff);
        rd(8'h30, q);
        check(q, 32'h0, "unmapped read");
        read_word <= 16'h5aa5;
        wr(port_pin_pkg::OFF_PULL, 32'h3f);
        wr(port_pin_pkg::OFF_FUNC, 32'h30);
        wait_cyc(4);
        rd(port_pin_pkg::OFF_STATUS, q);
        check(q & 32'h07, 32'h02, "expansion status");
        check({8'h0, pull_en}, 32'h0, "pulls off");
        check({bus_active, bus_wide}, 32'h3, "wide bus");
        check(bus_rdata, 32'h5aa5, "bus read");
        bus_wdata <= 16'hc33c;
        bus_drive <= 1'b1;
        wait_cyc(3);
        check({pin_oe[15:0], pin_out[15:0]}, 32'hffffc33c, "bus drive");
        bus_drive <= 1'b0;
    endtask : expand_test

    task automatic micro_test;
        logic [31:0] q;
        do_reset(1'b1, 1'b1);
        mode_strap <= 1'b0;
        rd(port_pin_pkg::OFF_STATUS, q);
        check(q & 32'h17, 32'h14, "micro status");
        wr(port_pin_pkg::OFF_PULL, 32'h3f);
        wr(port_pin_pkg::OFF_FUNC, 32'h10);
        wait_cyc(4);
        check({8'h0, pull_en}, 32'h0, "micro pulls off");
        check({bus_active, bus_wide}, 32'h2, "narrow bus");
        check(bus_rdata, 32'h00a5, "narrow read");
        rd(port_pin_pkg::OFF_STATUS, q);
        check(q & 32'h17, 32'h14, "mode kept");
    endtask : micro_test

    initial
    begin
        {rst, cyc, stb, we, mode_strap, width_strap, bus_drive} = '0;
        {adr, sel, wdat, bus_wdata, read_word, ext_level} = '0;
        failures   = 0;
        n_compared = 0;
        cycles     = 0;
        do_reset(1'b0, 1'b0);
        reset_test();
        dir_test();
        pull_adc_test();
        irq_test();
        expand_test();
        micro_test();
        final_report();
    end
endmodule : testbench
